// ===== common/pcint_pkg.sv
// Purpose: Constants for the pin-change detect block
// Assumes: Avalon-MM slave, 32-bit data, byte offsets
// Notes: Overview below lists the behaviour in brief
//
// Overview of operation
// [R1] Any pin combination may raise change interrupt
// [R2] Per-pin rising detector, armed by enable bit
// [R3] Per-pin falling detector, armed by enable bit
// [R4] Both enables set detect either polarity
// [R5] Enabled edge sets flag; irq needs master
// [R6] Master off: flags still set, no irq
// [R7] Summary flag set while any pin flag set
// [R8] Writing zero clears a pin change flag
// [R9] Edge during clear write leaves flag set
// [R10] Software clears flags by AND-mask write
// [R11] Enabled change wakes from Sleep with master
// [R12] Sleep edge recorded before first instruction
// [R13] Edge enables reset to zero on reset
// [R14] Flags are RW, hardware-set, reset zero
// [R15] Synchronise pins, compare samples for edges
package pcint_pkg;
  localparam int PCINT_PINS = 8;
  localparam int PCINT_AW = 4;
  // ==========================================================
  // Register byte offsets
  localparam logic [PCINT_AW-1:0] PCINT_OFS_RISE = 4'h0;
  localparam logic [PCINT_AW-1:0] PCINT_OFS_FALL = 4'h4;
  localparam logic [PCINT_AW-1:0] PCINT_OFS_FLAGS = 4'h8;
  localparam logic [PCINT_AW-1:0] PCINT_OFS_CTRL = 4'hC;
  // ==========================================================
  // Control register fields
  localparam int PCINT_CTRL_MASTER_BIT = 3;
  localparam int PCINT_CTRL_SUMMARY_BIT = 0;
  // ==========================================================
  // Reset values
  localparam logic [7:0] PCINT_RST_EN = 8'h00;
  localparam logic [7:0] PCINT_RST_FLAGS = 8'h00;
  localparam logic PCINT_RST_MASTER = 1'b0;
  localparam logic [31:0] PCINT_RD_UNMAPPED = 32'h0000_0000;
  typedef enum logic [1:0] {
    PCINT_BUS_IDLE = 2'b01,
    PCINT_BUS_DONE = 2'b10
  } pcint_bus_t;
endpackage

// ===== dv/pcint_pins.sv
// Purpose: External logic driving the watched pins
// Assumes: Levels change just after a clock edge
// Notes: Pins never float, so no unknown edges
`timescale 1ns/1ps
`default_nettype none
module pcint_pins (
  input wire logic i_clk_sys,
  input wire logic [7:0] i_level,
  output logic [7:0] o_pin
);
  // Registered, so a change never lands on a sampling edge
  always_ff @(posedge i_clk_sys) begin
    o_pin <= i_level;
  end
endmodule // pcint_pins
`default_nettype wire

// ===== dv/pcint_top_properties.sv
// Purpose: Port checks for pcint_top
// Assumes: One clock, reset active high
// Notes: Flags are seen through reads and irq only
`timescale 1ns/1ps
`default_nettype none
module pcint_props (
  input wire logic i_clk_sys,
  input wire logic i_rst,
  input wire logic [pcint_pkg::PCINT_AW-1:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  input wire logic [31:0] o_avs_readdata,
  input wire logic o_avs_waitrequest,
  input wire logic o_irq,
  input wire logic o_wake
);
  import pcint_pkg::*;
  logic rtk, wtk;
  assign rtk = i_avs_read && !o_avs_waitrequest;
  assign wtk = i_avs_write && !o_avs_waitrequest;
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (i_rst);
  // ==========================================================
  // Assertions
  a_wait_first:
    assert property ($rose(i_avs_read || i_avs_write) |-> o_avs_waitrequest)
    else $error("no wait cycle");
  a_wait_one:
    assert property ((i_avs_read || i_avs_write) && o_avs_waitrequest
    |=> !o_avs_waitrequest) else $error("wait too long");
  a_wake_irq:
    assert property (o_wake == o_irq) else $error("wake differs from irq");
  a_master_off:
    assert property (wtk && i_avs_address == PCINT_OFS_CTRL
    && !i_avs_writedata[3] |-> ##2 !o_irq) else $error("irq without master");
  a_summary_irq:
    assert property (rtk && i_avs_address == PCINT_OFS_CTRL && o_irq
    |=> o_avs_readdata[0] && o_avs_readdata[3]) else $error("summary low");
  a_unmapped_zero:
    assert property (rtk && i_avs_address[1:0] != 2'h0
    |=> o_avs_readdata == 32'h0) else $error("unmapped read not zero");
  a_upper_zero:
    assert property (rtk |=> o_avs_readdata[31:8] == 24'h0)
    else $error("upper read bits set");
  a_reset_quiet:
    assert property ($fell(i_rst) |-> !o_irq [*4])
    else $error("irq after reset");
  cover property ($rose(o_irq));
  cover property (rtk && i_avs_address[1:0] != 2'h0);
  cover property (wtk && i_avs_address == PCINT_OFS_FLAGS);
endmodule // pcint_props
bind pcint_top pcint_props u_props (.i_clk_sys, .i_rst, .i_avs_address,
  .i_avs_read, .i_avs_write, .i_avs_writedata, .o_avs_readdata,
  .o_avs_waitrequest, .o_irq, .o_wake);
`default_nettype wire

// ===== dv/pcint_top_tb.sv
// Purpose: Self-checking bench for pcint_top
// Assumes: Avalon master waits for waitrequest low
// Notes: Rows cover edge enables, odd cases follow
`timescale 1ns/1ps
`default_nettype none
module pcint_top_tb;
  import pcint_pkg::*;
  logic clk = 0, rst = 1, rd = 0, wr = 0, irq, wake, wt;
  logic [3:0] adr = 4'h0;
  logic [31:0] wd = 32'h0, q, rdat;
  logic [7:0] lvl = 8'h00, pin;
  int error_cnt = 0, total_checks = 0;
  // Rise, fall, start level, end level, expected flags
  logic [39:0] rows [6] = '{40'hFF_00_00_FF_FF, 40'h00_FF_FF_00_FF,
    40'h0F_F0_00_FF_0F, 40'h81_81_00_81_81, 40'h3C_3C_FF_C3_3C,
    40'h00_00_00_FF_00};
  always #2.5 clk = ~clk;
  pcint_pins u_pins (.i_clk_sys(clk), .i_level(lvl), .o_pin(pin));
  pcint_top u_dut (.i_clk_sys(clk), .i_rst(rst), .i_watched_pin(pin),
    .i_avs_address(adr), .i_avs_read(rd), .i_avs_write(wr),
    .i_avs_writedata(wd), .i_avs_byteenable(4'hF), .o_avs_readdata(rdat),
    .o_avs_waitrequest(wt), .o_irq(irq), .o_wake(wake));
  task automatic chk(input string n, input logic [31:0] s, e);
    total_checks++;
    if (s !== e) begin
      error_cnt++;
      $display("BAD %s exp %h got %h", n, e, s);
    end
  endtask
  task automatic acc(input logic w, input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    rd <= !w;
    wr <= w;
    adr <= a;
    wd <= {24'h0, d};
    do @(posedge clk); while (wt !== 1'b0);
    q = rdat;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask
  task automatic close_out;
    if (error_cnt == 0 && total_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    #20us;
    error_cnt++;
    close_out;
  end
  initial begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    for (int a = 0; a < 16; a += 4) begin
      acc(0, a[3:0], 8'h00);
      chk("reset", q, 32'h0); // cleared
    end
    acc(1, PCINT_OFS_CTRL, 8'h08);
    foreach (rows[i]) begin
      acc(1, PCINT_OFS_RISE, rows[i][39:32]);
      acc(1, PCINT_OFS_FALL, rows[i][31:24]);
      lvl <= rows[i][23:16];
      repeat (8) @(posedge clk);
      acc(1, PCINT_OFS_FLAGS, 8'h00);
      lvl <= rows[i][15:8];
      repeat (8) @(posedge clk);
      acc(0, PCINT_OFS_FLAGS, 8'h00);
      chk("flags", q, {24'h0, rows[i][7:0]}); // edge flags
      chk("irq", {31'h0, irq}, 32'(|rows[i][7:0])); // irq level
      acc(0, PCINT_OFS_CTRL, 8'h00);
      chk("ctrl", q, 32'h8 | 32'(|rows[i][7:0])); // summary bit
    end
    acc(0, 4'h2, 8'h00);
    chk("unmapped", q, 32'h0);
    acc(1, PCINT_OFS_CTRL, 8'h00);
    acc(1, PCINT_OFS_FALL, 8'h01);
    // Edge timed to land on the clearing write
    lvl <= 8'hFE;
    @(posedge clk);
    acc(1, PCINT_OFS_FLAGS, 8'h00);
    acc(0, PCINT_OFS_FLAGS, 8'h00);
    chk("set wins", q, 32'h1); // flag kept
    chk("no irq", {31'h0, irq}, 32'h0); // master off
    acc(1, PCINT_OFS_FLAGS, q[7:0] & ~8'h01); // masked clear
    acc(0, PCINT_OFS_FLAGS, 8'h00);
    chk("cleared", q, 32'h0); // flag cleared
    close_out;
  end
endmodule // pcint_top_tb
`default_nettype wire

// ===== src/pcint_top.sv
// Purpose: Pin-change edge detect, flags, irq and wake
// Assumes: One clock, pins asynchronous to it
// Notes: Every access answers one cycle after request
`timescale 1ns/1ps
`default_nettype none
module pcint_top #(
  parameter int PINS = pcint_pkg::PCINT_PINS
) (
  input wire logic i_clk_sys,
  input wire logic i_rst,
  input wire logic [PINS-1:0] i_watched_pin,
  input wire logic [pcint_pkg::PCINT_AW-1:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  input wire logic [3:0] i_avs_byteenable,
  output logic [31:0] o_avs_readdata,
  output logic o_avs_waitrequest,
  output logic o_irq,
  output logic o_wake
);
  import pcint_pkg::*;

  // ==========================================================
  // Pin synchronisers and edge detect
  logic [PINS-1:0] sync_a;
  logic [PINS-1:0] sync_b;
  logic [PINS-1:0] prev;
  logic [PINS-1:0] rise_detect_enable;
  logic [PINS-1:0] fall_detect_enable;
  logic [PINS-1:0] pin_change_flags;
  logic [PINS-1:0] edge_hit;
  logic change_irq_master_enable;
  logic change_summary_flag;
  pcint_bus_t bus_state;
  logic acc_wr;
  logic acc_rd;

  // [R15] Two-stage sync, sample compare
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      sync_a <= '0;
      sync_b <= '0;
      prev <= '0;
    end else begin
      sync_a <= i_watched_pin;
      sync_b <= sync_a;
      prev <= sync_b;
    end
  end

  genvar g;
  generate
    for (g = 0; g < PINS; g++) begin : g_pin
      // [R1] [R2] [R3] [R4] Per-pin armed detectors
      assign edge_hit[g] =
        (rise_detect_enable[g] & sync_b[g] & ~prev[g]) |
        (fall_detect_enable[g] & ~sync_b[g] & prev[g]);
    end
  endgenerate

  // ==========================================================
  // Avalon slave: one wait cycle, then answer
  // Write lands only at the edge where waitrequest is low
  assign acc_wr = i_avs_write & (bus_state == PCINT_BUS_DONE);
  assign acc_rd = i_avs_read & (bus_state == PCINT_BUS_IDLE);
  assign o_avs_waitrequest = (i_avs_read | i_avs_write) &
                             (bus_state == PCINT_BUS_IDLE);

  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      bus_state <= PCINT_BUS_IDLE;
    end else begin
      case (bus_state)
        PCINT_BUS_IDLE: begin
          if (i_avs_read | i_avs_write) begin
            bus_state <= PCINT_BUS_DONE;
          end
        end
        PCINT_BUS_DONE: begin
          bus_state <= PCINT_BUS_IDLE;
        end
        default: begin
          bus_state <= PCINT_BUS_IDLE;
        end
      endcase
    end
  end

  // [R13] Enables cleared by any reset
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      rise_detect_enable <= PINS'(PCINT_RST_EN);
      fall_detect_enable <= PINS'(PCINT_RST_EN);
      change_irq_master_enable <= PCINT_RST_MASTER;
    end else if (acc_wr && i_avs_byteenable[0]) begin
      case (i_avs_address)
        PCINT_OFS_RISE: rise_detect_enable <= i_avs_writedata[PINS-1:0];
        PCINT_OFS_FALL: fall_detect_enable <= i_avs_writedata[PINS-1:0];
        PCINT_OFS_CTRL: begin
          change_irq_master_enable <=
            i_avs_writedata[PCINT_CTRL_MASTER_BIT];
        end
        default: begin
        end
      endcase
    end
  end

  // [R5] [R6] [R14] Flags set regardless of master
  // [R8] [R9] Written value lands, new edge wins
  // Set beats clear so AND-mask writes lose no edge
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      pin_change_flags <= PINS'(PCINT_RST_FLAGS);
    end else if (acc_wr && i_avs_byteenable[0] &&
                 i_avs_address == PCINT_OFS_FLAGS) begin
      pin_change_flags <= i_avs_writedata[PINS-1:0] | edge_hit;
    end else begin
      pin_change_flags <= pin_change_flags | edge_hit;
    end
  end

  // [R7] Summary of all pin flags
  assign change_summary_flag = |pin_change_flags;

  // Read data registered; answer lands with waitrequest low
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      o_avs_readdata <= PCINT_RD_UNMAPPED;
    end else if (acc_rd) begin
      o_avs_readdata <= PCINT_RD_UNMAPPED;
      case (i_avs_address)
        PCINT_OFS_RISE: o_avs_readdata[PINS-1:0] <= rise_detect_enable;
        PCINT_OFS_FALL: o_avs_readdata[PINS-1:0] <= fall_detect_enable;
        PCINT_OFS_FLAGS: o_avs_readdata[PINS-1:0] <= pin_change_flags;
        PCINT_OFS_CTRL: begin
          o_avs_readdata[PCINT_CTRL_MASTER_BIT] <=
            change_irq_master_enable;
          o_avs_readdata[PCINT_CTRL_SUMMARY_BIT] <= change_summary_flag;
        end
        default: begin
        end
      endcase
    end
  end

  // ==========================================================
  // Interrupt and wake outputs
  // [R5] [R6] [R11] [R12] Flag stored before wake shows
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      o_irq <= 1'b0;
      o_wake <= 1'b0;
    end else begin
      o_irq <= change_irq_master_enable & change_summary_flag;
      o_wake <= change_irq_master_enable & change_summary_flag;
    end
  end
endmodule // pcint_top
`default_nettype wire
